// *** common/pptoer_pkg.sv ***
package pptoer_pkg;
	// Register map, byte addresses on a 12-bit window
	localparam int unsigned PPTOER_AW = 12;
	localparam logic [11:0] PPTOER_OFS_PECNT = 12'h74C;
	localparam logic [11:0] PPTOER_OFS_TOCTL = 12'h750;
	localparam logic [11:0] PPTOER_OFS_TOSTS = 12'h754;
	localparam logic [11:0] PPTOER_OFS_TORSEL = 12'h758;
	localparam logic [11:0] PPTOER_OFS_IRQSTS = 12'h770;
	localparam logic [11:0] PPTOER_OFS_IRQMSK = 12'h774;

	// Queue classes: posted, non-posted, completion, insertion
	localparam int unsigned PPTOER_NQ = 4;
	localparam int unsigned PPTOER_Q_POSTED = 0;
	localparam int unsigned PPTOER_Q_NONPOSTED = 1;
	localparam int unsigned PPTOER_Q_COMPLETION = 2;
	localparam int unsigned PPTOER_Q_INSERTION = 3;

	// Parity error counter field
	localparam int unsigned PPTOER_CNT_W = 8;
	localparam logic [7:0] PPTOER_CNT_MAX = 8'hFF;
	localparam logic [7:0] PPTOER_CNT_ONE = 8'h01;
	localparam logic [7:0] PPTOER_CNT_RST = 8'h00;

	// Time-out enable field
	localparam int unsigned PPTOER_TOEN_BIT = 0;
	localparam logic PPTOER_TOEN_RST = 1'b1;
	localparam logic [3:0] PPTOER_TOSTS_RST = 4'h0;

	// Reporting selector fields, two bits per class
	localparam int unsigned PPTOER_SEL_W = 2;
	localparam logic [1:0] PPTOER_SEL_NONE = 2'h0;
	localparam logic [1:0] PPTOER_SEL_COR = 2'h1;
	localparam logic [1:0] PPTOER_SEL_NONFATAL = 2'h2;
	localparam logic [1:0] PPTOER_SEL_FATAL = 2'h3;
	localparam logic [7:0] PPTOER_TORSEL_RST = 8'h82;

	// Interrupt status and mask layout
	localparam int unsigned PPTOER_IRQ_W = 5;
	localparam int unsigned PPTOER_IRQ_PE_BIT = 0;
	localparam int unsigned PPTOER_IRQ_Q_LSB = 1;
	localparam logic [4:0] PPTOER_IRQ_RST = 5'h00;

	// Bus answers
	localparam logic [1:0] PPTOER_RESP_OKAY = 2'h0;
	localparam logic [1:0] PPTOER_RESP_SLVERR = 2'h2;
	localparam logic [31:0] PPTOER_WORD_ZERO = 32'h00000000;
endpackage

// *** core/pptoer_regs.sv ***
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Count each end-to-end parity error in an 8-bit counter, bits 7:0.
// - Counter saturates at all-ones, never wraps to zero.
// - Reading the counter returns its value, then clears it.
// - Time-out enable is bit 0, enabled after reset.
// - While enabled, discard packets overstaying the core time-out.
// - Posted queue time-out discard sets status bit 0.
// - Non-posted queue time-out discard sets status bit 1.
// - Completion queue time-out discard sets status bit 2.
// - Insertion queue time-out discard sets status bit 3.
// - Report a time-out only on its status bit rising, per selector.
// - Selector: 0 none, 1 correctable, 2 non-fatal, 3 fatal.
// - Non-posted selector is bits 3:2, resets to none.
// - Completion selector is bits 5:4, resets to none.
// - Insertion selector is bits 7:6, resets to non-fatal.
module pptoer_regs
	import pptoer_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic por_n,
	input wire logic parity_err,
	input wire logic [3:0] overstay,
	output logic [3:0] discard,
	output logic err_cor,
	output logic err_nonfatal,
	output logic err_fatal,
	output logic irq,
	input wire logic [11:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [11:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0] cnt_q, cnt_d;
	logic toen_q, toen_d;
	logic [3:0] sts_q, sts_d;
	logic [7:0] rsel_q, rsel_d;
	logic [4:0] ists_q, ists_d;
	logic [4:0] imsk_q, imsk_d;
	logic [3:0] discard_q;
	logic cor_q, nf_q, fat_q;
	logic irq_q;
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Any reset clears the non-sticky state
	wire rst_any = ~aresetn | ~por_n;

	////////////////////////////////////////////////////////////////////////
	// Bus handshake decode
	// Ready pulses one cycle after both address and data are seen
	wire wr_start = awvalid & wvalid & ~awready_q & ~bvalid_q;
	wire wr_fire = awvalid & awready_q & wvalid & wready_q & aresetn;
	wire rd_start = arvalid & ~arready_q & ~rvalid_q;
	wire rd_fire = arvalid & arready_q & aresetn;
	wire lane0 = wr_fire & wstrb[0]; // All fields live in byte 0

	wire wa_ctl = awaddr == PPTOER_OFS_TOCTL;
	wire wa_sts = awaddr == PPTOER_OFS_TOSTS;
	wire wa_sel = awaddr == PPTOER_OFS_TORSEL;
	wire wa_ists = awaddr == PPTOER_OFS_IRQSTS;
	wire wa_imsk = awaddr == PPTOER_OFS_IRQMSK;
	wire wa_cnt = awaddr == PPTOER_OFS_PECNT;
	wire wr_hit = wa_ctl | wa_sts | wa_sel | wa_ists | wa_imsk | wa_cnt;

	wire wr_ctl = lane0 & wa_ctl;
	wire wr_sel = lane0 & wa_sel;
	wire wr_imsk = lane0 & wa_imsk;
	wire [3:0] sts_clr = (lane0 & wa_sts) ? wdata[3:0] : 4'h0;
	wire [4:0] ists_clr = (lane0 & wa_ists) ? wdata[4:0] : 5'h00;

	// Read selection
	wire ra_cnt = araddr == PPTOER_OFS_PECNT;
	wire ra_ctl = araddr == PPTOER_OFS_TOCTL;
	wire ra_sts = araddr == PPTOER_OFS_TOSTS;
	wire ra_sel = araddr == PPTOER_OFS_TORSEL;
	wire ra_ists = araddr == PPTOER_OFS_IRQSTS;
	wire ra_imsk = araddr == PPTOER_OFS_IRQMSK;
	wire rd_hit = ra_cnt | ra_ctl | ra_sts | ra_sel | ra_ists | ra_imsk;
	wire [31:0] rd_word =
		ra_cnt ? {24'h000000, cnt_q} :
		ra_ctl ? {31'h00000000, toen_q} :
		ra_sts ? {28'h0000000, sts_q} :
		ra_sel ? {24'h000000, rsel_q} :
		ra_ists ? {27'h0000000, ists_q} :
		ra_imsk ? {27'h0000000, imsk_q} : PPTOER_WORD_ZERO;

	// Read side effect on the counter
	wire rc_clear = rd_fire & ra_cnt;

	////////////////////////////////////////////////////////////////////////
	// Parity error counter
	// An error in the clearing cycle counts as one, so none is lost
	wire cnt_full = cnt_q == PPTOER_CNT_MAX;
	wire [7:0] cnt_inc = cnt_q + PPTOER_CNT_ONE;
	assign cnt_d = rc_clear ? (parity_err ? PPTOER_CNT_ONE : PPTOER_CNT_RST) :
		(parity_err & ~cnt_full) ? cnt_inc : cnt_q;

	////////////////////////////////////////////////////////////////////////
	// Time-out enable, discard and write-one-to-clear status
	assign toen_d = wr_ctl ? wdata[PPTOER_TOEN_BIT] : toen_q;
	// Queue timers flag overstays; gating here keeps one enable point
	wire [3:0] discard_d = overstay & {4{toen_q}};
	// Set wins over a same-cycle write-one clear
	assign sts_d = (sts_q & ~sts_clr)
		| discard_q;
	assign rsel_d = wr_sel ? wdata[7:0] : rsel_q;

	////////////////////////////////////////////////////////////////////////
	// Per-class reporting on a zero-to-one status edge
	wire [3:0] rise = discard_q & ~sts_q;
	logic [3:0] rep_cor, rep_nf, rep_fat;
	genvar gi;
	generate
		for (gi = 0; gi < PPTOER_NQ; gi++)
		begin : g_class
			// Field gi sits at bits 2*gi+1:2*gi
			wire [1:0] sel =
				rsel_q[gi*PPTOER_SEL_W +: PPTOER_SEL_W];
			assign rep_cor[gi] = rise[gi] & (sel == PPTOER_SEL_COR);
			assign rep_nf[gi] = rise[gi]
				& (sel == PPTOER_SEL_NONFATAL);
			assign rep_fat[gi] = rise[gi]
				& (sel == PPTOER_SEL_FATAL);

			a_sts_set_bit: assert property (
				@(posedge aclk) disable iff (rst_any)
				discard_q[gi] |=> sts_q[gi])
				else $error("status bit not set by discard");

			a_sts_bit_hold: assert property (
				@(posedge aclk) disable iff (rst_any)
				sts_q[gi] && !sts_clr[gi] |=> sts_q[gi])
				else $error("status bit dropped without clear");

			a_report_fatal: assert property (
				@(posedge aclk) disable iff (rst_any)
				rise[gi] && sel == PPTOER_SEL_FATAL |=> fat_q)
				else $error("fatal report missing");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Interrupt status and mask
	wire [4:0] ists_set = {discard_q, parity_err};
	assign ists_d = (ists_q & ~ists_clr) | ists_set;
	assign imsk_d = wr_imsk ? wdata[4:0] : imsk_q;
	wire irq_d = |(ists_d & imsk_d);

	////////////////////////////////////////////////////////////////////////
	// Sticky state: only power-on reset clears it
	always_ff @(posedge aclk)
	begin
		if (!por_n)
		begin
			cnt_q <= PPTOER_CNT_RST;
			toen_q <= PPTOER_TOEN_RST;
			rsel_q <= PPTOER_TORSEL_RST;
		end
		else
		begin
			cnt_q <= cnt_d;
			toen_q <= toen_d;
			rsel_q <= rsel_d;
		end
	end

	// Event state, cleared by either reset
	always_ff @(posedge aclk)
	begin
		if (rst_any)
		begin
			sts_q <= PPTOER_TOSTS_RST;
			discard_q <= 4'h0;
			ists_q <= PPTOER_IRQ_RST;
			imsk_q <= PPTOER_IRQ_RST;
			irq_q <= 1'b0;
		end
		else
		begin
			sts_q <= sts_d;
			discard_q <= discard_d;
			ists_q <= ists_d;
			imsk_q <= imsk_d;
			irq_q <= irq_d;
		end
	end

	// Error message strobes, one cycle each
	always_ff @(posedge aclk)
	begin
		if (rst_any)
		begin
			cor_q <= 1'b0;
			nf_q <= 1'b0;
			fat_q <= 1'b0;
		end
		else
		begin
			cor_q <= |rep_cor;
			nf_q <= |rep_nf;
			fat_q <= |rep_fat;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write channel: one write in flight
	always_ff @(posedge aclk)
	begin
		if (rst_any)
		begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= PPTOER_RESP_OKAY;
		end
		else
		begin
			awready_q <= wr_start;
			wready_q <= wr_start;
			if (wr_fire)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? PPTOER_RESP_OKAY : PPTOER_RESP_SLVERR;
			end
			else if (bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read channel: one read in flight
	always_ff @(posedge aclk)
	begin
		if (rst_any)
		begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= PPTOER_WORD_ZERO;
			rresp_q <= PPTOER_RESP_OKAY;
		end
		else
		begin
			arready_q <= rd_start;
			if (rd_fire)
			begin
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? PPTOER_RESP_OKAY : PPTOER_RESP_SLVERR;
			end
			else if (rready)
				rvalid_q <= 1'b0;
		end
	end

	// Outputs straight from flops
	assign discard = discard_q;
	assign err_cor = cor_q;
	assign err_nonfatal = nf_q;
	assign err_fatal = fat_q;
	assign irq = irq_q;
	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_cnt_increment: assert property (
		@(posedge aclk) disable iff (rst_any)
		parity_err && !cnt_full && !rc_clear |=>
		cnt_q == $past(cnt_q) + PPTOER_CNT_ONE)
		else $error("counter did not increment");

	a_cnt_saturate: assert property (
		@(posedge aclk) disable iff (rst_any)
		cnt_full && !rc_clear |=> cnt_full)
		else $error("counter wrapped");

	a_cnt_read_clear: assert property (
		@(posedge aclk) disable iff (rst_any)
		rc_clear && !parity_err |=>
		cnt_q == PPTOER_CNT_RST && rvalid_q &&
		rdata_q[7:0] == $past(cnt_q))
		else $error("read did not return then clear");

	a_discard_gate: assert property (
		@(posedge aclk) disable iff (rst_any)
		1'b1 |=> discard_q == ($past(overstay) & {4{$past(toen_q)}}))
		else $error("discard not gated by enable");

	a_no_report: assert property (
		@(posedge aclk) disable iff (rst_any)
		rise == 4'h0 |=> !cor_q && !nf_q && !fat_q)
		else $error("report without status rise");

	a_por_defaults: assert property (
		@(posedge aclk)
		!por_n |=> toen_q == PPTOER_TOEN_RST &&
		rsel_q == PPTOER_TORSEL_RST && sts_q == PPTOER_TOSTS_RST)
		else $error("power-on defaults wrong");

	a_sticky_keep: assert property (
		@(posedge aclk)
		!aresetn && por_n |=> toen_q == $past(toen_q) &&
		rsel_q == $past(rsel_q))
		else $error("sticky state lost on warm reset");

	a_irq_level: assert property (@(posedge aclk) disable iff (rst_any)
		irq_q == |(ists_q & imsk_q))
		else $error("irq level mismatch");

	a_bvalid_hold: assert property (@(posedge aclk) disable iff (rst_any)
		bvalid_q && !bready |=> bvalid_q && $stable(bresp_q))
		else $error("write answer dropped early");

	c_cnt_saturated: cover property (@(posedge aclk) disable iff (rst_any)
		cnt_full && parity_err);
	c_clear_with_err: cover property (@(posedge aclk) disable iff (rst_any)
		rc_clear && parity_err);
	c_fatal_report: cover property (@(posedge aclk) disable iff (rst_any)
		fat_q);
	c_irq_raised: cover property (@(posedge aclk) disable iff (rst_any)
		$rose(irq_q));

endmodule // pptoer_regs

// *** dv/pptoer_regs_test.sv ***
`timescale 1ns/10ps
module pptoer_regs_test
	import pptoer_pkg::*;
;
	localparam logic [1:0] RSP_OK = PPTOER_RESP_OKAY;
	localparam logic [1:0] RSP_ERR = PPTOER_RESP_SLVERR;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic por_n = 1'b0;
	logic parity_err = 1'b0;
	logic [3:0] overstay = 4'h0;
	logic [3:0] discard;
	logic err_cor, err_nonfatal, err_fatal, irq;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_fail = 0;
	int n_checks = 0;
	int n_cor = 0, n_nf = 0, n_fat = 0;

	pptoer_regs uut (.aclk(aclk), .aresetn(aresetn), .por_n(por_n),
		.parity_err(parity_err), .overstay(overstay), .discard(discard),
		.err_cor(err_cor), .err_nonfatal(err_nonfatal), .err_fatal(err_fatal),
		.irq(irq), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready));

	////////////////////////////////////////////////////////////////////////
	// Clock, 100 ns period
	always #50 aclk = ~aclk;

	// Message strobes counted per kind, one count per pulse cycle
	always @(posedge aclk)
	begin
		if (err_cor === 1'b1) n_cor++;
		if (err_nonfatal === 1'b1) n_nf++;
		if (err_fatal === 1'b1) n_fat++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask

	task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED at %0t: resp %h exp %h", $time, got, exp);
		end
	endtask

	// Write master; trailing edge keeps a following call from
	// assigning the same valid twice in one time step
	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// No cycle count assumed; only the watchdog ends a hung wait
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk_resp(bresp, er);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// Read master with comparison of data and response
	task automatic rd(input logic [11:0] a, input logic [31:0] exp,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		chk_word(rdata, exp, "read data");
		chk_resp(rresp, er);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	task automatic par(input int n);
		parity_err <= 1'b1;
		repeat (n) @(posedge aclk);
		parity_err <= 1'b0;
		@(posedge aclk);
	endtask

	// One overstay cycle; discard is read one edge later
	task automatic stay(input int q, input logic [3:0] ed);
		overstay <= 4'h1 << q;
		@(posedge aclk);
		overstay <= 4'h0;
		@(posedge aclk);
		chk_word({28'h0, discard}, {28'h0, ed}, "discard");
		repeat (3) @(posedge aclk);
	endtask

	task automatic chk_irq(input logic e);
		repeat (3) @(posedge aclk);
		chk_word({31'h0, irq}, {31'h0, e}, "irq");
	endtask

	task automatic chk_msgs(input int c, input int nf, input int f);
		chk_word(n_cor, c, "cor count");
		chk_word(n_nf, nf, "nonfatal count");
		chk_word(n_fat, f, "fatal count");
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		$display("CHECK FAILED at %0t: watchdog", $time);
		complete_run();
	end

	// Main sequence
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		por_n <= 1'b1;
		@(posedge aclk);
		rd(PPTOER_OFS_PECNT, 32'h0, RSP_OK);
		rd(PPTOER_OFS_TOCTL, 32'h1, RSP_OK);
		rd(PPTOER_OFS_TOSTS, 32'h0, RSP_OK);
		rd(PPTOER_OFS_TORSEL, 32'h82,
			RSP_OK);
		$display("test reset values done");
		par(3);
		rd(PPTOER_OFS_PECNT, 32'h3, RSP_OK);
		rd(PPTOER_OFS_PECNT, 32'h0, RSP_OK);
		par(300);
		rd(PPTOER_OFS_PECNT, 32'hFF, RSP_OK);
		rd(PPTOER_OFS_PECNT, 32'h0, RSP_OK);
		$display("test parity counter done");
		// Selector code equals class index, so every code is used once
		wr(PPTOER_OFS_TORSEL, 32'hE4, RSP_OK);
		rd(PPTOER_OFS_TORSEL, 32'hE4,
			RSP_OK);
		wr(PPTOER_OFS_IRQMSK, 32'h1F, RSP_OK);
		wr(PPTOER_OFS_IRQSTS, 32'h1F, RSP_OK);
		for (int q = 0; q < 4; q++)
		begin
			stay(q, 4'h1 << q);
			chk_msgs(q >= 1, q >= 2, q >= 3);
			rd(PPTOER_OFS_TOSTS, (32'h2 << q) - 1, RSP_OK);
		end
		chk_irq(1'b1);
		rd(PPTOER_OFS_IRQSTS, 32'h1E, RSP_OK);
		// Bits already set: no new messages
		for (int q = 0; q < 4; q++)
			stay(q, 4'h1 << q);
		chk_msgs(1, 1, 1);
		wr(PPTOER_OFS_TOSTS, 32'h0, RSP_OK);
		rd(PPTOER_OFS_TOSTS, 32'hF, RSP_OK);
		wr(PPTOER_OFS_TOSTS, 32'h5, RSP_OK);
		rd(PPTOER_OFS_TOSTS, 32'hA, RSP_OK);
		wr(PPTOER_OFS_TOSTS, 32'hA, RSP_OK);
		rd(PPTOER_OFS_TOSTS, 32'h0, RSP_OK);
		wr(PPTOER_OFS_IRQSTS, 32'h1E, RSP_OK);
		chk_irq(1'b0);
		$display("test discard reporting done");
		wr(PPTOER_OFS_TOCTL, 32'h0, RSP_OK);
		stay(1, 4'h0);
		rd(PPTOER_OFS_TOSTS, 32'h0, RSP_OK);
		wr(PPTOER_OFS_TOCTL, 32'h1, RSP_OK);
		$display("test enable done");
		// Masked event holds status but not the line
		wr(PPTOER_OFS_IRQMSK, 32'h0, RSP_OK);
		par(1);
		chk_irq(1'b0);
		rd(PPTOER_OFS_IRQSTS, 32'h1, RSP_OK);
		wr(PPTOER_OFS_IRQMSK, 32'h1, RSP_OK);
		chk_irq(1'b1);
		wr(PPTOER_OFS_IRQSTS, 32'h1, RSP_OK);
		chk_irq(1'b0);
		wr(PPTOER_OFS_PECNT, 32'h12, RSP_OK);
		rd(PPTOER_OFS_PECNT, 32'h1, RSP_OK);
		wr(12'h7F0, 32'h1, RSP_ERR);
		rd(12'h7F0, 32'h0, RSP_ERR);
		$display("test interrupt and map done");
		wr(PPTOER_OFS_TOCTL, 32'h0, RSP_OK);
		wr(PPTOER_OFS_TORSEL, 32'h55, RSP_OK);
		par(2);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(PPTOER_OFS_PECNT, 32'h2, RSP_OK);
		rd(PPTOER_OFS_TOCTL, 32'h0, RSP_OK);
		rd(PPTOER_OFS_TORSEL, 32'h55, RSP_OK);
		por_n <= 1'b0;
		repeat (2) @(posedge aclk);
		por_n <= 1'b1;
		@(posedge aclk);
		rd(PPTOER_OFS_PECNT, 32'h0, RSP_OK);
		rd(PPTOER_OFS_TOCTL, 32'h1, RSP_OK);
		rd(PPTOER_OFS_TORSEL, 32'h82, RSP_OK);
		$display("test sticky reset done");
		complete_run();
	end
endmodule // pptoer_regs_test
